// >>> hdl/ddb_pkg.sv
package ddb_pkg;

  // ****************************************************************
  // sizes of the configuration area and of the driver chain
  // ****************************************************************
  localparam int CODE_W       = 5;   // selection code width
  localparam int WORD_W       = 6;   // next-driver flag plus code
  localparam int CFG_ADDRS    = 32;  // ram addresses of the area
  localparam int CFG_WORDS    = 64;  // two words per address
  localparam int PTR_W        = 6;   // word pointer width
  localparam int IDX_W        = 2;   // driver position index width
  localparam int MOTORS       = 3;   // drivers in the chain
  localparam int DAC_W        = 6;   // coil current dac width
  localparam int SIG_W        = 20;  // primary signals per motor

  // ****************************************************************
  // primary signal codes
  // ****************************************************************
  localparam logic [4:0] CODE_DAC_A0    = 5'h00;
  localparam logic [4:0] CODE_A_POL     = 5'h06;
  localparam logic [4:0] CODE_A_QD      = 5'h07;
  localparam logic [4:0] CODE_DAC_B0    = 5'h08;
  localparam logic [4:0] CODE_B_POL     = 5'h0E;
  localparam logic [4:0] CODE_B_QD      = 5'h0F;
  localparam logic [4:0] CODE_ZERO      = 5'h10;
  localparam logic [4:0] CODE_ONE       = 5'h11;
  localparam logic [4:0] CODE_DIR       = 5'h12;
  localparam logic [4:0] CODE_STEP      = 5'h13;
  localparam logic [4:0] CODE_FIRST_RSV = 5'h14;

  // ****************************************************************
  // avalon register map, byte addresses
  // ****************************************************************
  localparam int          ADDR_W         = 9;
  localparam logic [8:0]  OFS_CTRL       = 9'h000;
  localparam logic [8:0]  OFS_STATUS     = 9'h004;
  localparam logic [8:0]  OFS_CFG_BASE   = 9'h100;
  localparam logic [8:0]  OFS_CFG_LAST   = 9'h17C;

  // ctrl fields
  localparam int          CTRL_LAST_LSB  = 0;
  localparam int          CTRL_START_BIT = 8;
  // status fields
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_PEND_BIT  = 1;
  localparam int          STAT_IDX_LSB   = 4;
  // ram word layout inside a bus word
  localparam int          CFG_EVEN_LSB   = 0;
  localparam int          CFG_ODD_LSB    = 6;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [1:0]  RST_LAST_IDX   = 2'h0;
  localparam logic [31:0] RST_RDATA      = 32'h0000_0000;

  // shifter states
  typedef enum logic [1:0] {
    DDB_IDLE,
    DDB_SHIFT,
    DDB_CLOSE
  } ddb_state_e;

endpackage : ddb_pkg

// >>> hdl/ddb_datagram_builder.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// ******************************************************************
// Overview of operation
// ******************************************************************
module ddb_datagram_builder
  import ddb_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // avalon-mm slave
  input  wire logic [ddb_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // primary signals from the microstep unit, one slice per motor
  input  wire logic [17:0]                  coil_a_dac,
  input  wire logic [2:0]                   coil_a_polarity,
  input  wire logic [2:0]                   coil_a_quick_decay,
  input  wire logic [17:0]                  coil_b_dac,
  input  wire logic [2:0]                   coil_b_polarity,
  input  wire logic [2:0]                   coil_b_quick_decay,
  input  wire logic [2:0]                   motor_direction,
  input  wire logic [2:0]                   motor_step,
  // datagram request from the motion units
  input  wire logic                         xfer_req,
  // driver chain link
  input  wire logic                         link_clk,
  output logic                              drv_data,
  output logic                              drv_sel_n,
  output logic                              drv_busy
);
  import ddb_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [WORD_W-1:0]  cfg_ram [CFG_WORDS];
  wire  [SIG_W-1:0]   live_sig [MOTORS];
  logic [SIG_W-1:0]   snap_q   [MOTORS];
  ddb_state_e         state_q;
  ddb_state_e         state_d;
  logic [PTR_W-1:0]   ptr_q;
  logic [IDX_W-1:0]   idx_q;
  logic [IDX_W-1:0]   last_idx_q;
  logic               pend_q;
  logic               waitreq_q;
  logic [31:0]        rdata_q;
  logic               lclk_s1_q;
  logic               lclk_s2_q;
  logic               lclk_s3_q;
  logic               frame_start;
  logic               word_step;
  logic               close_step;

  // ****************************************************************
  // link clock sampling
  // ****************************************************************
  // two flops against metastability; only the second reads the first
  // both rest at the idle high level of the link clock, so leaving
  // reset shows no false fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lclk_s1_q <= 1'b1;
      lclk_s2_q <= 1'b1;
    end else begin
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
    end
  end

  // third flop only for edge finding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lclk_s3_q <= 1'b1;
    end else begin
      lclk_s3_q <= lclk_s2_q;
    end
  end

  // a fall is seen two to three clocks late, so each link half period
  // must last at least four clocks for the data to settle in time
  // data changes on the falling edge, chain samples on the rising one
  wire lclk_fall = lclk_s3_q & ~lclk_s2_q;

  // ****************************************************************
  // primary signal vectors, bit position equals selection code
  // ****************************************************************
  genvar m;
  generate
    for (m = 0; m < MOTORS; m++) begin : g_sig
      // coil signals, the two constants, then the motion bits
      assign live_sig[m][DAC_W-1:0]          =
        coil_a_dac[m*DAC_W +: DAC_W];
      assign live_sig[m][CODE_A_POL]         = coil_a_polarity[m];
      assign live_sig[m][CODE_A_QD]          = coil_a_quick_decay[m];
      assign live_sig[m][CODE_DAC_B0 +: DAC_W] =
        coil_b_dac[m*DAC_W +: DAC_W];
      assign live_sig[m][CODE_B_POL]         = coil_b_polarity[m];
      assign live_sig[m][CODE_B_QD]          = coil_b_quick_decay[m];
      assign live_sig[m][CODE_ZERO]          = 1'b0;
      assign live_sig[m][CODE_ONE]           = 1'b1;
      assign live_sig[m][CODE_DIR]           = motor_direction[m];
      assign live_sig[m][CODE_STEP]          = motor_step[m];

      // snapshot held for the whole datagram, not reset on purpose
      always_ff @(posedge clk) begin
        if (frame_start) begin
          snap_q[m] <= live_sig[m];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // request phases: taken on the first edge, done on the second
  wire bus_req     = avs_read | avs_write;
  wire bus_take    = bus_req & waitreq_q;       // first cycle of request
  wire bus_done    = bus_req & ~waitreq_q;      // completing edge

  // register and ram window decode
  wire sel_ctrl    = (avs_address == OFS_CTRL);
  wire sel_status  = (avs_address == OFS_STATUS);
  wire sel_cfg     = (avs_address >= OFS_CFG_BASE) &&
                     (avs_address <= OFS_CFG_LAST) &&
                     (avs_address[1:0] == 2'b00);

  // ram row from the byte offset, two words to a row
  wire [8:0] cfg_off = avs_address - OFS_CFG_BASE;
  wire [4:0] cfg_row = cfg_off[6:2];
  wire [5:0] even_a  = {cfg_row, 1'b0};
  wire [5:0] odd_a   = {cfg_row, 1'b1};

  // writes act on the completing edge only
  wire wr_cfg      = bus_done & avs_write & sel_cfg;
  wire wr_ctrl     = bus_done & avs_write & sel_ctrl;
  wire sw_start    = wr_ctrl & avs_writedata[CTRL_START_BIT];

  // read data selection, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux[CTRL_LAST_LSB +: IDX_W] = last_idx_q;
    end else if (sel_status) begin
      rd_mux[STAT_BUSY_BIT] = drv_busy;
      rd_mux[STAT_PEND_BIT] = pend_q;
      rd_mux[STAT_IDX_LSB +: IDX_W] = idx_q;
    end else if (sel_cfg) begin
      rd_mux[CFG_EVEN_LSB +: WORD_W] = cfg_ram[even_a];
      rd_mux[CFG_ODD_LSB  +: WORD_W] = cfg_ram[odd_a];
    end
  end

  // ****************************************************************
  // avalon handshake: one wait state, answer on the second edge
  // ****************************************************************
  // waitrequest drops for one cycle after each taken request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= ~bus_take;
    end
  end

  // read data latched at the taking edge; it stands until the next
  // access is taken, so a slow master still sees it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RST_RDATA;
    end else if (bus_take) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata    = rdata_q;

  // ****************************************************************
  // control register
  // ****************************************************************
  // last driver index, read back as written
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_idx_q <= RST_LAST_IDX;
    end else if (wr_ctrl) begin
      last_idx_q <= avs_writedata[CTRL_LAST_LSB +: IDX_W];
    end
  end

  // ****************************************************************
  // configuration ram
  // ****************************************************************
  // separate write port from the bus and read port to the shifter,
  // so software may rewrite the order while a frame is running
  always_ff @(posedge clk) begin
    if (wr_cfg) begin
      cfg_ram[even_a] <= avs_writedata[CFG_EVEN_LSB +: WORD_W];
      cfg_ram[odd_a]  <= avs_writedata[CFG_ODD_LSB  +: WORD_W];
    end
  end

  // ****************************************************************
  // current configuration word and selected bit
  // ****************************************************************
  // word under the pointer, split into flag and code
  wire [WORD_W-1:0] cur_word  = cfg_ram[ptr_q];
  wire              nxt_flag  = cur_word[WORD_W-1];
  wire [CODE_W-1:0] cur_code  = cur_word[CODE_W-1:0];
  wire              code_rsv  = (cur_code >= CODE_FIRST_RSV);

  // a chain position past the last motor has no snapshot; it sends
  // a defined one, as the reserved codes do, instead of unknowns
  localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(MOTORS - 1);
  wire              idx_ok    = (idx_q <= IDX_TOP);
  wire [IDX_W-1:0]  snap_idx  = idx_ok ? idx_q : '0;
  wire [SIG_W-1:0]  cur_snap  = snap_q[snap_idx];
  // reserved codes give a defined one
  wire              sel_bit   = (code_rsv || !idx_ok) ? 1'b1 :
                                cur_snap[cur_code];
  wire              at_last   = (idx_q == last_idx_q);

  // ****************************************************************
  // request pending flag
  // ****************************************************************
  // a request that meets the frame start is kept for the next frame
  // set wins over clear, so no request is ever lost
  wire req_in      = xfer_req | sw_start;
  assign frame_start = (state_q == DDB_IDLE) & pend_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (req_in) begin
      pend_q <= 1'b1;
    end else if (frame_start) begin
      pend_q <= 1'b0;
    end
  end

  // ****************************************************************
  // shifter state machine
  // ****************************************************************
  // next state: wait, shift words, then one more fall to close
  always_comb begin
    state_d = state_q;
    case (state_q)
      DDB_IDLE: begin
        if (pend_q) begin
          state_d = DDB_SHIFT;
        end
      end
      DDB_SHIFT: begin
        if (lclk_fall && nxt_flag && at_last) begin
          state_d = DDB_CLOSE;
        end
      end
      DDB_CLOSE: begin
        if (lclk_fall) begin
          state_d = DDB_IDLE;
        end
      end
      default: begin
        state_d = DDB_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= DDB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // frame strobes
  // ****************************************************************
  // one strobe per link fall while shifting; the close strobe ends
  // the frame one link period after the last bit
  assign word_step  = (state_q == DDB_SHIFT) & lclk_fall;
  assign close_step = (state_q == DDB_CLOSE) & lclk_fall;

  // ****************************************************************
  // word pointer and driver index
  // ****************************************************************
  // the pointer wraps, so a ram with no flag set keeps the frame
  // open forever; that is wanted, not a hang
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= '0;
    end else if (frame_start) begin
      ptr_q <= '0;
    end else if (word_step) begin
      ptr_q <= ptr_q + 6'h01;
    end
  end

  // driver index steps on each flag until the last driver is reached
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= '0;
    end else if (frame_start) begin
      idx_q <= '0;
    end else if (word_step && nxt_flag && at_last) begin
      idx_q <= '0;
    end else if (word_step && nxt_flag) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  // ****************************************************************
  // link outputs
  // ****************************************************************
  // busy follows the next state, so it moves in step with select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_busy <= 1'b0;
    end else begin
      drv_busy <= (state_d != DDB_IDLE);
    end
  end

  // select drops with the start and rises one link period after the
  // last bit went out, so the last bit is still sampled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_sel_n <= 1'b1;
    end else if (frame_start) begin
      drv_sel_n <= 1'b0;
    end else if (close_step) begin
      drv_sel_n <= 1'b1;
    end
  end

  // data moves three clocks after a link fall, well before the rise
  // at which the chain samples; parked low between frames
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_data <= 1'b0;
    end else if (word_step) begin
      drv_data <= sel_bit;
    end else if (close_step) begin
      drv_data <= 1'b0;
    end
  end

endmodule : ddb_datagram_builder

// >>> testbench/ddb_chk_sva.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module ddb_chk
  import ddb_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // link
  input wire logic              xfer_req,
  input wire logic              link_clk,
  input wire logic              drv_data,
  input wire logic              drv_sel_n,
  input wire logic              drv_busy
);
  logic seen_req_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // any request at all, conservative: every write counts
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) seen_req_q <= 1'b0;
    else if (xfer_req || avs_write) seen_req_q <= 1'b1;
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  hole_zero_a: assert property (
    avs_read && avs_waitrequest && avs_address >= 9'h180
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  req_start_a: assert property (
    xfer_req && drv_sel_n && !drv_busy |-> ##[1:3] !drv_sel_n)
    else $error("requested frame did not start");
  quiet_rst_a: assert property (
    !seen_req_q |-> drv_sel_n) else $error("frame without request");
  sel_busy_a: assert property (
    drv_busy != drv_sel_n) else $error("busy and select disagree");
  data_idle_a: assert property (
    drv_sel_n |-> !drv_data) else $error("data not low outside frame");
  data_edge_a: assert property (
    !drv_sel_n && !$past(drv_sel_n) && $changed(drv_data)
    |-> !$past(link_clk)) else $error("data moved off link fall");
  busy_hold_a: assert property (
    $rose(drv_busy) |-> drv_busy [*8]) else $error("frame too short");
  c_frame: cover property ($fell(drv_sel_n));
  c_hole: cover property (avs_read && avs_address >= 9'h180);
  c_write: cover property (avs_write && avs_address == OFS_CTRL);
endmodule : ddb_chk

bind ddb_datagram_builder ddb_chk u_chk (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .xfer_req(xfer_req), .link_clk(link_clk), .drv_data(drv_data),
  .drv_sel_n(drv_sel_n), .drv_busy(drv_busy));

// >>> testbench/ddb_chain_model.sv
`timescale 1ns/1ps
// ****
// driver chain: clocks only inside frames, shifts in on rise
// ****
module ddb_chain_model (
  // link
  input wire logic        drv_data,
  input wire logic        drv_sel_n,
  output logic            link_clk,
  // captured frame
  output logic            frm_done,
  output logic [63:0]     frm_bits,
  output logic [6:0]      frm_len
);
  initial begin
    link_clk = 1'b1;
    frm_done = 1'b0;
    frm_bits = '0;
    frm_len = '0;
    forever begin
      @(negedge drv_sel_n);
      #7;
      frm_bits = '0;
      frm_len = '0;
      while (!drv_sel_n) begin
        #100 link_clk = 1'b0;
        #100 link_clk = 1'b1;
        if (!drv_sel_n && frm_len < 64) begin
          frm_bits[frm_len[5:0]] = drv_data;
          frm_len = frm_len + 7'h01;
        end
      end
      frm_done = 1'b1;
      #30 frm_done = 1'b0;
    end
  end
endmodule : ddb_chain_model

// >>> testbench/test_driver_chain_datagram_builder.sv
`timescale 1ns/1ps
module test_driver_chain_datagram_builder;
  import ddb_pkg::*;
  logic              clk, nrst, avs_read, avs_write, xfer_req, link_clk;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rd;
  logic              avs_waitrequest, drv_data, drv_sel_n, drv_busy;
  logic              frm_done;
  logic [17:0]       dac_a, dac_b;
  logic [2:0]        pol_a, qd_a, pol_b, qd_b, dir, stp;
  logic [63:0]       frm_bits;
  logic [6:0]        frm_len;
  logic [5:0]        ram [64];
  logic [70:0]       expq [$];
  int                miscompares = 0, total_checks = 0, cycles = 0;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  ddb_datagram_builder dut (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .coil_a_dac(dac_a), .coil_a_polarity(pol_a),
    .coil_a_quick_decay(qd_a), .coil_b_dac(dac_b),
    .coil_b_polarity(pol_b), .coil_b_quick_decay(qd_b),
    .motor_direction(dir), .motor_step(stp), .xfer_req(xfer_req),
    .link_clk(link_clk), .drv_data(drv_data), .drv_sel_n(drv_sel_n),
    .drv_busy(drv_busy));
  ddb_chain_model chain (.drv_data(drv_data), .drv_sel_n(drv_sel_n),
    .link_clk(link_clk), .frm_done(frm_done), .frm_bits(frm_bits),
    .frm_len(frm_len));

  task summarize;
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [70:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
    end
  endtask : chk

  // one avalon access; holds until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [8:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  // expected bit for a code of motor m
  function automatic logic pick(input logic [4:0] c, input int m);
    case (c) inside
      [5'h00:5'h05]: return dac_a[6*m+c];
      5'h06: return pol_a[m];
      5'h07: return qd_a[m];
      [5'h08:5'h0D]: return dac_b[6*m+c-8];
      5'h0E: return pol_b[m];
      5'h0F: return qd_b[m];
      5'h10: return 1'b0;
      5'h12: return dir[m];
      5'h13: return stp[m];
      default: return 1'b1;
    endcase
  endfunction : pick

  task automatic note_frame(input int last);
    logic [63:0] b;
    int          k, m;
    b = '0;
    m = 0;
    for (k = 0; k < 64; k++) begin
      b[k] = pick(ram[k][4:0], m);
      if (ram[k][5]) begin
        if (m == last) break;
        m++;
      end
    end
    expq.push_back({7'(k + 1), b});
  endtask : note_frame

  task automatic shake;
    dac_a <= 18'($urandom);
    dac_b <= 18'($urandom);
    {pol_a, qd_a, pol_b, qd_b, dir, stp} <= 18'($urandom);
  endtask : shake

  // ****
  // watcher: oldest note against each captured frame
  // ****
  always @(posedge frm_done) begin
    if (expq.size() == 0) begin
      miscompares++;
      $display("unexpected at %0t: frame without note", $time);
    end else chk({frm_len, frm_bits}, expq.pop_front(), "frame");
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    {avs_read, avs_write, xfer_req, nrst} = '0;
    avs_address = '0;
    avs_writedata = '0;
    {dac_a, dac_b, pol_a, qd_a, pol_b, qd_b, dir, stp} = '0;
    rd = $urandom(32'h4318);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    // every code once in words 0 to 31, repeated in 32 to 63; drivers end at words 10, 20, 31
    for (int k = 0; k < 64; k++) ram[k] = {k==10 || k==20 || k==31, 5'(k)};
    for (int r = 0; r < 32; r++)
      bus(1, OFS_CFG_BASE + 9'(4*r), {20'h0, ram[2*r+1], ram[2*r]}, rd);
    bus(0, OFS_CFG_BASE + 9'h14, '0, rd);
    chk(71'(rd), 71'({ram[11], ram[10]}), "cfg row");
    bus(0, 9'h180, '0, rd);
    chk(71'(rd), 71'h0, "hole");
    for (int last = 2; last >= 0; last--) begin
      shake();
      bus(1, OFS_CTRL, 32'(last), rd);
      bus(0, OFS_CTRL, '0, rd);
      chk(71'(rd), 71'(last), "ctrl readback");
      if (last == 1) bus(1, OFS_CTRL, 32'(last) | 32'h100, rd);
      else begin
        xfer_req <= 1'b1;
        @(posedge clk);
        xfer_req <= 1'b0;
      end
      note_frame(last);
      repeat (6) @(posedge clk);
      shake();
      bus(0, OFS_CFG_BASE, '0, rd);
      chk(71'(rd), 71'({ram[1], ram[0]}), "busy read");
      bus(0, OFS_STATUS, '0, rd);
      chk(71'(rd[STAT_BUSY_BIT]), 71'h1, "busy flag");
      while (drv_busy !== 1'b0) @(posedge clk);
      repeat (20) @(posedge clk);
    end
    if (expq.size() != 0) begin
      miscompares++;
      $display("unexpected at %0t: notes left over", $time);
    end
    summarize();
  end
endmodule : test_driver_chain_datagram_builder
